// File: tfc_counter.sv
// trace fifo valid word counter with ahb-lite register access
`timescale 1ns/1ns
// Functional notes
// - power-on reset and any reset that does not end a trace run clear the whole count register.
// - after a reset that ends a trace run the design holds the count value in every case.
// - an end-type run ending in reset with enable set and begin select clear keeps the count.
// - bits seven to four of the count register read zero and ignore writes.
// - the count reports the number of valid fifo words in plain binary from zero to eight.
// - the count stops at eight even while more words are captured.
// - the count clears whenever the debug module is armed, except when an end-run reset in the same cycle holds it.
// - each word captured while the debug module is enabled adds one to the count, up to the limit.
// - reading words out of the fifo never changes the count.
// - with begin select set, the end-of-run break request waits until eight words are held.
module tfc_counter
  import tfc_pkg::*;
#(
  parameter int               CNT_W   = TFC_CNT_W,          // width of the valid word count
  parameter logic [CNT_W-1:0] CNT_MAX = CNT_W'(TFC_CNT_MAX) // value at which the count stops
)
(
  input  wire logic        hclk,            // core clock
  input  wire logic        hresetn,         // power-on reset, active low
  input  wire logic        hsel,            // ahb slave select
  input  wire logic [31:0] haddr,           // ahb address
  input  wire logic [1:0]  htrans,          // ahb transfer type
  input  wire logic        hwrite,          // ahb write
  input  wire logic [2:0]  hsize,           // ahb size, word only
  input  wire logic [31:0] hwdata,          // ahb write data
  input  wire logic        hready,          // ahb bus ready
  output logic      [31:0] hrdata,          // ahb read data
  output logic             hreadyout,       // ahb slave ready
  output logic             hresp,           // ahb response
  input  wire logic        sys_rst,         // synchronous system reset, active high
  input  wire logic        sys_rst_end_run, // this reset ends a trace run
  input  wire logic        arm_event,       // debug module became armed, pulse
  input  wire logic        word_captured,   // word written into trace fifo, pulse
  input  wire logic        brk_trigger,     // end-of-run break request from trigger logic
  output logic             brk_request,     // break request to the cpu
  output logic [CNT_W-1:0] valid_word_count // current count
);

  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(TFC_CNT_RESET);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam int               PAD_W    = 32 - CNT_W;

  tfc_ctrl_t            ctrl_reg;
  tfc_aphase_t          aphase_reg;
  logic [CNT_W-1:0]     count_reg;
  logic [CNT_W-1:0]     count_next;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  logic                 brk_pend_reg;
  logic                 keep_count;
  logic                 take;
  logic                 at_max;
  logic                 cap_ok;
  logic                 rst_end_run;
  logic                 brk_set;

  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
    addr_hit = (a[31:2] == off[31:2]);
  endfunction

  // a reset that does not end a run is treated like power-on for the count and control registers
  function automatic logic clears_all(input logic rst, input logic end_run);
    clears_all = rst && !end_run;
  endfunction

  assign take      = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = rdata_reg;
  assign valid_word_count = count_reg;

  assign rst_end_run = sys_rst && sys_rst_end_run;
  assign at_max      = (count_reg == CNT_MAX);
  // captures with the module disabled are not counted, the fifo does not store them
  assign cap_ok      = word_captured && ctrl_reg.debug_module_enable && !at_max;

  // an end-run reset keeps the count; the hold case is the enabled end-type run
  assign keep_count = sys_rst_end_run && ctrl_reg.debug_module_enable
                      && !ctrl_reg.begin_trigger_select;

  // fifo reads have no path into this logic, so the count falls only on arming or a clearing reset
  always_comb begin
    count_next = count_reg;
    // arming wins over a capture in the same cycle: the new run starts empty
    if (arm_event) begin
      count_next = CNT_ZERO;
    end else if (cap_ok) begin
      count_next = count_reg + CNT_ONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= CNT_ZERO;
    end else if (clears_all(sys_rst, sys_rst_end_run)) begin
      count_reg <= CNT_ZERO;
    end else if (rst_end_run) begin
      // other end-run resets also hold: the value is unspecified there anyway
      if (!keep_count) begin
        count_reg <= count_reg;
      end
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase_reg <= '0;
    end else if (hready) begin
      aphase_reg.valid <= take;
      aphase_reg.write <= hwrite;
      aphase_reg.addr  <= haddr;
    end
  end

  // control survives an end-run reset so the hold decision stays consistent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= '0;
    end else if (clears_all(sys_rst, sys_rst_end_run)) begin
      ctrl_reg <= '0;
    end else if (aphase_reg.valid && aphase_reg.write
                 && addr_hit(aphase_reg.addr, TFC_CTRL_OFFSET)) begin
      ctrl_reg.debug_module_enable  <= hwdata[TFC_CTRL_EN_BIT];
      ctrl_reg.begin_trigger_select <= hwdata[TFC_CTRL_BG_BIT];
    end
  end

  // read data is fetched at the address phase; the count register is read only
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (take && !hwrite) begin
      if (addr_hit(haddr, TFC_CNT_OFFSET)) begin
        rdata_next = {{PAD_W{1'b0}}, count_reg};
      end else if (addr_hit(haddr, TFC_CTRL_OFFSET)) begin
        rdata_next = {30'h0000_0000, ctrl_reg.begin_trigger_select,
                      ctrl_reg.debug_module_enable};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign brk_set = brk_trigger && ctrl_reg.debug_module_enable;

  // begin-type runs release the break only once the fifo is full;
  // a trigger in the delivery cycle wins over the clear so it is not lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_pend_reg <= 1'b0;
    end else if (sys_rst || arm_event) begin
      brk_pend_reg <= 1'b0;
    end else if (brk_set) begin
      brk_pend_reg <= 1'b1;
    end else if (brk_request) begin
      brk_pend_reg <= 1'b0;
    end
  end

  assign brk_request = brk_pend_reg && (!ctrl_reg.begin_trigger_select || at_max);

endmodule

// File: tfc_pkg.sv
// shared constants and types for the trace fifo valid word counter
package tfc_pkg;
  localparam logic [31:0] TFC_CNT_OFFSET  = 32'h0000_0000;
  localparam logic [31:0] TFC_CTRL_OFFSET = 32'h0000_0004;
  localparam int          TFC_CNT_W       = 4;
  localparam logic [3:0]  TFC_CNT_MAX     = 4'h8;
  localparam logic [3:0]  TFC_CNT_RESET   = 4'h0;
  localparam int          TFC_CTRL_EN_BIT = 0;
  localparam int          TFC_CTRL_BG_BIT = 1;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
  localparam logic        HRESP_OKAY      = 1'b0;

  typedef struct packed {
    logic begin_trigger_select;
    logic debug_module_enable;
  } tfc_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } tfc_aphase_t;
endpackage

// File: tfc_monitor.sv
// port assertions for the trace fifo valid word counter
`timescale 1ns/1ns
module tfc_monitor
  import tfc_pkg::*;
(
  input wire logic        hclk,             // clock
  input wire logic        hresetn,          // reset
  input wire logic        hsel,             // select
  input wire logic [31:0] haddr,            // address
  input wire logic [1:0]  htrans,           // transfer
  input wire logic        hwrite,           // write
  input wire logic        hready,           // ready
  input wire logic [31:0] hrdata,           // read data
  input wire logic        sys_rst,          // sys reset
  input wire logic        sys_rst_end_run,  // ends run
  input wire logic        arm_event,        // arm
  input wire logic        word_captured,    // capture
  input wire logic [3:0]  valid_word_count, // count
  input wire logic        hreadyout,        // slave ready
  input wire logic        hresp,            // response
  input wire logic        brk_trigger,      // break trigger
  input wire logic        brk_request       // break request
);
  wire [3:0] c    = valid_word_count;
  wire       idle = !word_captured && !arm_event && !sys_rst;
  wire       rd0  = hsel && hready && htrans[1] && !hwrite && haddr == TFC_CNT_OFFSET;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RANGE: assert property (c <= 4'h8) else $error("count over eight");
  AST_STEP: assert property ($changed(c) |-> c == 4'h0 ||
    (c == $past(c) + 4'h1 && $past(word_captured))) else $error("bad step");
  AST_HOLD: assert property (idle |=> $stable(c)) else $error("count moved");
  AST_SAT: assert property (c == 4'h8 && idle |=> c == 4'h8) else $error("left eight");
  AST_ARM: assert property (arm_event |=> c == 4'h0) else $error("arm kept count");
  AST_CLR: assert property (sys_rst && !sys_rst_end_run |=> c == 4'h0) else $error("no clear");
  AST_KEEP: assert property (sys_rst && sys_rst_end_run && !arm_event |=> $stable(c))
    else $error("end run lost count");
  AST_RSV: assert property (rd0 |=> hrdata[31:4] == 28'h0) else $error("reserved set");
  AST_BRK_ONE: assert property (brk_request && !brk_trigger |=> !brk_request)
    else $error("break request held");
  AST_BUS: assert property (hreadyout && hresp == HRESP_OKAY) else $error("bus not okay");
endmodule
bind tfc_counter tfc_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .sys_rst, .sys_rst_end_run, .arm_event, .word_captured, .valid_word_count,
  .hreadyout, .hresp, .brk_trigger, .brk_request);

// File: test_tfc_counter.sv
// self-checking bench for the trace fifo valid word counter
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module test_tfc_counter;
  import tfc_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dph = 0;
  logic        sys_rst = 0, sys_rst_end_run = 0, arm_event = 0, word_captured = 0;
  logic        brk_trigger = 0;
  logic [31:0] haddr = 0, hwdata = 0, exp_v, q[$], exp_b, bq[$];
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  wire  [31:0] hrdata;
  wire  [3:0]  valid_word_count;
  wire         hreadyout, hresp, brk_request;
  wire         hready = hreadyout;
  int          num_errors = 0, cmp_count = 0, n;
  always #5 hclk = ~hclk;
  tfc_counter dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .sys_rst, .sys_rst_end_run, .arm_event, .word_captured,
    .brk_trigger, .brk_request, .valid_word_count);
  // read data is judged only in its data phase, one note per read
  always @(posedge hclk) if (dph) begin
    exp_v = q.pop_front();
    `CHK(hrdata, exp_v)
    `CHK({hreadyout, hresp}, {1'b1, HRESP_OKAY})
  end
  // each break request takes the oldest noted count; an unnoted one cannot match
  always @(posedge hclk) if (brk_request === 1'b1) begin
    exp_b = (bq.size() > 0) ? bq.pop_front() : 32'hffff_ffff;
    `CHK({28'h0, valid_word_count}, exp_b)
  end
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk); hsel <= 1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d; dph <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    dph <= 0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e); xfer(a, 0, 32'h0);
  endtask
  task automatic cap(input int k);
    @(posedge hclk); word_captured <= 1; repeat (k) @(posedge hclk); word_captured <= 0;
  endtask
  task automatic arm;
    @(posedge hclk); arm_event <= 1; @(posedge hclk); arm_event <= 0;
  endtask
  task automatic trig;
    @(posedge hclk); brk_trigger <= 1; @(posedge hclk); brk_trigger <= 0;
  endtask
  task automatic srst(input logic e);
    @(posedge hclk); sys_rst <= 1; sys_rst_end_run <= e;
    @(posedge hclk); sys_rst <= 0; sys_rst_end_run <= 0;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000 num_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(6330));
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    xfer(TFC_CTRL_OFFSET, 1, 32'h1); rd(TFC_CNT_OFFSET, 32'h0);
    n = $urandom_range(7, 1);
    arm; cap(n); rd(TFC_CNT_OFFSET, n);
    cap(9); rd(TFC_CNT_OFFSET, 32'h8); rd(TFC_CNT_OFFSET, 32'h8);
    xfer(TFC_CNT_OFFSET, 1, $urandom()); rd(TFC_CNT_OFFSET, 32'h8); rd(32'h8, 32'h0);
    $display("counting and register tests done");
    srst(1); rd(TFC_CNT_OFFSET, 32'h8);
    arm; rd(TFC_CNT_OFFSET, 32'h0);
    cap(3); srst(0); cap(2); rd(TFC_CNT_OFFSET, 32'h0);
    $display("reset tests done");
    xfer(TFC_CTRL_OFFSET, 1, 32'h3); arm; bq.push_back(32'h8); trig;
    cap(8); rd(TFC_CNT_OFFSET, 32'h8);
    xfer(TFC_CTRL_OFFSET, 1, 32'h1); arm; cap(n); bq.push_back(n); trig;
    rd(TFC_CNT_OFFSET, n);
    `CHK(bq.size(), 0)
    $display("break tests done");
    end_sim;
  end
endmodule
